// ### ccl_map.svh
// Register map, field positions and reset values of the comparator control logic
//
// Overview of operation
// R01 - Result bit high while selected positive input exceeds selected negative input.
// R02 - Mux enabled and converter off: channel field picks channel 0..7 as negative input.
// R03 - Mux disabled or converter on: dedicated negative pin is used.
// R04 - Reference select set feeds bandgap to positive input, else positive pin.
// R05 - Raw comparator output is synchronised; readable result lags one to two cycles.
// R06 - Event flag set when an output transition matches the edge mode.
// R07 - Event flag clears automatically when the interrupt vector is executed.
// R08 - Writing one clears the event flag; writing zero leaves it.
// R09 - Interrupt request only while flag, enable and global enable all set; the irq output needs only flag and irq_mask.
// R10 - Edge mode: 0 toggle, 1 reserved, 2 falling, 3 rising.
// R11 - Capture route bit connects result to timer capture front end, else none.
// R12 - Timer capture interrupt also needs the capture interrupt enable in timer mask.
// R13 - Power-off bit removes comparator power; may be set at any time.
// R14 - Software disables comparator interrupt before changing power-off bit.
// R15 - Software disables comparator interrupt before changing edge mode.
// R16 - Converter counts as on exactly when its enable bit is set.
// R17 - Events compare synchronised output with previous cycle; reserved mode gives none.
// R18 - After reset all control bits are zero.
`ifndef CCL_MAP_SVH
`define CCL_MAP_SVH
`define CCL_SFIO_OFFSET 12'h000
`define CCL_CSR_OFFSET 12'h004
`define CCL_IRQ_STATUS_OFFSET 12'h008
`define CCL_IRQ_MASK_OFFSET 12'h00c
`define CCL_SFIO_RESET 8'h00
`define CCL_CSR_RESET 8'h00
`define CCL_SFIO_MUXEN_BIT 3
`define CCL_CSR_POWER_OFF_BIT 7
`define CCL_CSR_BANDGAP_BIT 6
`define CCL_CSR_RESULT_BIT 5
`define CCL_CSR_FLAG_BIT 4
`define CCL_CSR_IRQ_EN_BIT 3
`define CCL_CSR_CAPTURE_BIT 2
`define CCL_EDGE_TOGGLE 2'h0
`define CCL_EDGE_RESERVED 2'h1
`define CCL_EDGE_FALLING 2'h2
`define CCL_EDGE_RISING 2'h3
`endif

// ### ccl_pkg.sv
// Types of the comparator control logic
package ccl_pkg;
  typedef enum logic [3:0] {
    CCL_MODE_TOGGLE = 4'h1,
    CCL_MODE_RESERVED = 4'h2,
    CCL_MODE_FALLING = 4'h4,
    CCL_MODE_RISING = 4'h8
  } ccl_mode_t;
  typedef struct packed {
    logic power_off;
    logic bandgap_select;
    logic irq_enable;
    logic capture_route;
    logic [1:0] edge_mode;
  } ccl_ctrl_t;
  typedef struct packed {
    logic use_bandgap;
    logic use_channel;
    logic [2:0] channel;
  } ccl_sel_t;
endpackage

// ### ccl_comparator_control.sv
// Comparator control logic: input selection, synchroniser, edge events, APB registers
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ccl_map.svh"
module ccl_comparator_control
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_raw,
  input wire logic converter_on,
  input wire logic [2:0] channel_select_field,
  input wire logic global_irq_enable,
  input wire logic vector_ack,
  output logic use_bandgap,
  output logic use_channel,
  output logic [2:0] channel_sel,
  output logic comparator_power_off,
  output logic capture_out,
  output logic comparator_irq,
  output logic irq
);
  logic negative_mux_enable;
  ccl_pkg::ccl_ctrl_t ctrl;
  logic comparator_event_flag;
  logic sync_1;
  logic sync_2;
  logic result_d;
  logic irq_mask;
  ccl_pkg::ccl_mode_t mode;
  ccl_pkg::ccl_sel_t next_sel;

  // APB decode; zero wait states
  wire access_w = psel && penable && pwrite && pstrb[0];
  wire hit_sfio = paddr == `CCL_SFIO_OFFSET;
  wire hit_csr = paddr == `CCL_CSR_OFFSET;
  wire hit_stat = paddr == `CCL_IRQ_STATUS_OFFSET;
  wire hit_mask = paddr == `CCL_IRQ_MASK_OFFSET;
  wire mapped = hit_sfio || hit_csr || hit_stat || hit_mask;
  wire wr_sfio = access_w && hit_sfio;
  wire wr_csr = access_w && hit_csr;
  wire wr_stat = access_w && hit_stat;
  wire wr_mask = access_w && hit_mask;

  // Converter counts as on only from its enable bit
  wire converter_active = converter_on; // see R16
  wire channel_path = negative_mux_enable && !converter_active; // see R02 see R03

  always_comb
  begin
    next_sel.use_bandgap = ctrl.bandgap_select; // see R04
    next_sel.use_channel = channel_path; // see R02 see R03
    next_sel.channel = channel_path ? channel_select_field : 3'h0; // see R03
  end

  // Edge mode decode to one-hot
  always_comb
  begin
    unique case (ctrl.edge_mode) // see R10
      `CCL_EDGE_TOGGLE: mode = ccl_pkg::CCL_MODE_TOGGLE;
      `CCL_EDGE_RESERVED: mode = ccl_pkg::CCL_MODE_RESERVED;
      `CCL_EDGE_FALLING: mode = ccl_pkg::CCL_MODE_FALLING;
      `CCL_EDGE_RISING: mode = ccl_pkg::CCL_MODE_RISING;
    endcase
  end

  wire rise = sync_2 && !result_d; // see R17
  wire fall = !sync_2 && result_d; // see R17
  wire event_hit = (mode == ccl_pkg::CCL_MODE_TOGGLE && (rise || fall))
    || (mode == ccl_pkg::CCL_MODE_FALLING && fall)
    || (mode == ccl_pkg::CCL_MODE_RISING && rise); // see R06 see R17
  wire flag_clear = (wr_csr && pwdata[`CCL_CSR_FLAG_BIT]) || (wr_stat && pwdata[0]) || vector_ack; // see R07 see R08
  // Set beats clear so a coincident event is never lost
  wire next_flag = event_hit || (comparator_event_flag && !flag_clear); // see R06 see R08
  wire next_irq = next_flag && ctrl.irq_enable && global_irq_enable; // see R09

  wire [7:0] sfio_rd = {4'h0, negative_mux_enable, 3'h0};
  wire [7:0] csr_rd = {ctrl.power_off, ctrl.bandgap_select, sync_2, comparator_event_flag,
    ctrl.irq_enable, ctrl.capture_route, ctrl.edge_mode}; // see R05
  wire [31:0] next_rdata = hit_sfio ? {24'h000000, sfio_rd}
    : hit_csr ? {24'h000000, csr_rd}
    : hit_stat ? {31'h00000000, comparator_event_flag}
    : hit_mask ? {31'h00000000, irq_mask} : 32'h00000000;

  // Synchroniser: first stage feeds only the second
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_1 <= 1'b0;
      sync_2 <= 1'b0;
      result_d <= 1'b0;
    end
    else
    begin
      sync_1 <= comparator_raw; // see R01 see R05
      sync_2 <= sync_1; // see R05
      result_d <= sync_2; // see R17
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      negative_mux_enable <= 1'b0; // see R18
      ctrl <= '0; // see R18
      irq_mask <= 1'b0;
    end
    else
    begin
      if (wr_sfio)
        negative_mux_enable <= pwdata[`CCL_SFIO_MUXEN_BIT];
      if (wr_csr)
        ctrl <= {pwdata[`CCL_CSR_POWER_OFF_BIT], pwdata[`CCL_CSR_BANDGAP_BIT], pwdata[`CCL_CSR_IRQ_EN_BIT],
          pwdata[`CCL_CSR_CAPTURE_BIT], pwdata[1:0]}; // see R13
      if (wr_mask)
        irq_mask <= pwdata[0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      comparator_event_flag <= 1'b0;
      comparator_irq <= 1'b0;
      irq <= 1'b0;
      use_bandgap <= 1'b0;
      use_channel <= 1'b0;
      channel_sel <= 3'h0;
      comparator_power_off <= 1'b0;
      capture_out <= 1'b0;
    end
    else
    begin
      comparator_event_flag <= next_flag; // see R06
      comparator_irq <= next_irq; // see R09
      irq <= next_flag && irq_mask;
      use_bandgap <= next_sel.use_bandgap; // see R04
      use_channel <= next_sel.use_channel; // see R02
      channel_sel <= next_sel.channel; // see R02
      comparator_power_off <= ctrl.power_off; // see R13
      // Timer owns filtering and edge select; we only gate the path
      capture_out <= ctrl.capture_route && sync_2; // see R11
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= next_rdata;
    end
  end

  // Event flag behaviour
  flag_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R06
    event_hit |=> comparator_event_flag)
    else $error("event did not set flag");

  flag_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R08
    comparator_event_flag && flag_clear && !event_hit |=> !comparator_event_flag)
    else $error("flag not cleared");

  vector_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R07
    vector_ack && !event_hit |=> !comparator_event_flag)
    else $error("vector did not clear flag");

  vector_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R06
    vector_ack && event_hit |=> comparator_event_flag)
    else $error("coincident event lost to vector");

  flag_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R08
    comparator_event_flag && !flag_clear |=> comparator_event_flag)
    else $error("flag dropped without clear");

  zero_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R08
    comparator_event_flag && wr_csr && !pwdata[`CCL_CSR_FLAG_BIT] && !vector_ack |=> comparator_event_flag)
    else $error("zero write cleared flag");

  status_w1c_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R08
    wr_stat && pwdata[0] && !event_hit |=> !comparator_event_flag)
    else $error("status write did not clear flag");

  no_spurious_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R06
    !comparator_event_flag && !event_hit |=> !comparator_event_flag)
    else $error("flag set without event");

  // Interrupt outputs
  irq_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R09
    comparator_irq |-> comparator_event_flag && $past(ctrl.irq_enable) && $past(global_irq_enable))
    else $error("irq without enables");

  irq_follow_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R09
    $past(reset_n) |-> comparator_irq == (comparator_event_flag && $past(ctrl.irq_enable) && $past(global_irq_enable)))
    else $error("irq does not follow flag");

  mask_irq_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(reset_n) |-> irq == (comparator_event_flag && $past(irq_mask)))
    else $error("masked irq wrong");

  mask_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_mask && pwdata[0] |=> irq_mask)
    else $error("mask write lost");

  // Synchroniser and edge detection
  first_stage_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R01
    $past(reset_n) |-> sync_1 == $past(comparator_raw))
    else $error("first stage wrong");

  result_track_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R05
    $past(reset_n) |-> sync_2 == $past(sync_1))
    else $error("second stage wrong");

  sync_lag_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R05
    $rose(comparator_raw) ##1 comparator_raw |=> sync_2)
    else $error("result lag wrong");

  delay_tap_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R17
    $past(reset_n) |-> result_d == $past(sync_2))
    else $error("previous result wrong");

  rise_detect_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R17
    $past(reset_n) && $rose(sync_2) |-> rise)
    else $error("rise not detected");

  fall_detect_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R17
    $past(reset_n) && $fell(sync_2) |-> fall)
    else $error("fall not detected");

  toggle_mode_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R10
    ctrl.edge_mode == `CCL_EDGE_TOGGLE && (rise || fall) |=> comparator_event_flag)
    else $error("toggle missed");

  falling_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R06
    ctrl.edge_mode == `CCL_EDGE_FALLING && fall |=> comparator_event_flag)
    else $error("falling edge missed");

  rising_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R06
    ctrl.edge_mode == `CCL_EDGE_RISING && rise |=> comparator_event_flag)
    else $error("rising edge missed");

  falling_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R10
    ctrl.edge_mode == `CCL_EDGE_FALLING && rise |-> !event_hit)
    else $error("rising edge in falling mode");

  rising_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R10
    ctrl.edge_mode == `CCL_EDGE_RISING && fall |-> !event_hit)
    else $error("falling edge in rising mode");

  reserved_quiet_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R17
    ctrl.edge_mode == `CCL_EDGE_RESERVED |-> !event_hit)
    else $error("reserved mode decoded an event");

  reserved_mode_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R17
    ctrl.edge_mode == `CCL_EDGE_RESERVED && !comparator_event_flag && !flag_clear |=> !comparator_event_flag)
    else $error("reserved mode made event");

  // Input selection and side outputs
  pin_select_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R03
    converter_on |=> !use_channel)
    else $error("channel used while converter on");

  pin_channel_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R03
    !negative_mux_enable |=> !use_channel && channel_sel == 3'h0)
    else $error("channel used while mux off");

  channel_pick_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R02
    negative_mux_enable && !converter_on |=> use_channel && channel_sel == $past(channel_select_field))
    else $error("channel not selected");

  bandgap_sel_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R04
    $past(reset_n) |-> use_bandgap == $past(ctrl.bandgap_select))
    else $error("positive input selection wrong");

  power_follow_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R13
    $past(reset_n) |-> comparator_power_off == $past(ctrl.power_off))
    else $error("power off not applied");

  capture_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R11
    !ctrl.capture_route |=> !capture_out)
    else $error("capture path without route");

  capture_follow_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R11
    ctrl.capture_route |=> capture_out == $past(sync_2))
    else $error("capture path does not follow result");

  // Register bus
  ready_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    psel && !penable |=> pready)
    else $error("no ready after setup");

  ready_once_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pready |=> !pready)
    else $error("ready longer than one cycle");

  idle_ready_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !psel |=> !pready)
    else $error("ready while idle");

  err_ready_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pslverr |-> pready)
    else $error("error without ready");

  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    psel && !penable && !mapped |=> prdata == 32'h00000000 && pslverr)
    else $error("unmapped access answered wrongly");

  upper_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  result_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R05
    psel && !penable && hit_csr |=> prdata[`CCL_CSR_RESULT_BIT] == $past(sync_2))
    else $error("result bit read wrong");

  sfio_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    psel && !penable && hit_sfio |=> prdata[`CCL_SFIO_MUXEN_BIT] == $past(negative_mux_enable))
    else $error("mux enable read wrong");

  // State right after reset
  ctrl_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R18
    !$past(reset_n) |-> ctrl == '0 && !negative_mux_enable)
    else $error("control bits not zero after reset");

  flag_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // see R18
    !$past(reset_n) |-> !comparator_event_flag && !comparator_irq && !irq)
    else $error("interrupt state not zero after reset");
endmodule
`default_nettype wire

// ### ccl_comp_model.sv
// Behavioural comparator core that answers the block's input selections
`timescale 1ns/100ps
`default_nettype none
module ccl_comp_model
#(
  parameter logic [7:0] BANDGAP_MV = 8'h80
)
(
  input wire logic use_bandgap,
  input wire logic use_channel,
  input wire logic [2:0] channel_sel,
  input wire logic comparator_power_off,
  input wire logic [7:0] pos_mv,
  input wire logic [7:0] neg_mv,
  input wire logic [63:0] ch_mv,
  output logic comparator_raw
);
  logic [7:0] plus_mv;
  logic [7:0] minus_mv;
  assign plus_mv = use_bandgap ? BANDGAP_MV : pos_mv;
  assign minus_mv = use_channel ? ch_mv[channel_sel * 8 +: 8] : neg_mv;
  // Unpowered core makes no decision
  assign comparator_raw = !comparator_power_off && (plus_mv > minus_mv);
endmodule
`default_nettype wire

// ### ccl_comparator_control_test.sv
// Self-checking testbench of the comparator control logic
`timescale 1ns/100ps
`default_nettype none
module ccl_comparator_control_test;
  logic ref_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic converter_on = 1'b0, global_irq_enable = 1'b1, vector_ack = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] channel_select_field = 3'h0, channel_sel;
  logic [7:0] pos_mv = 8'h20, neg_mv = 8'h40;
  logic pready, pslverr, err, use_bandgap, use_channel, comparator_power_off, capture_out, comparator_irq, irq;
  logic comparator_raw, fr, ff;
  logic [1:0] m;
  // Rows: special io ctrl, ctrl/status, converter on, channel field, expected selection outputs
  logic [25:0] rows [5] = '{
    {8'h08, 8'h00, 1'b0, 3'h5, 6'h0d},
    {8'h08, 8'h00, 1'b0, 3'h7, 6'h0f},
    {8'h08, 8'h00, 1'b1, 3'h3, 6'h00},
    {8'h00, 8'h40, 1'b0, 3'h0, 6'h10},
    {8'h00, 8'h80, 1'b0, 3'h6, 6'h20}};
  int errors = 0, comparisons = 0;
  ccl_comparator_control i_dut
  (
    .ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
    .comparator_raw, .converter_on, .channel_select_field, .global_irq_enable, .vector_ack, .use_bandgap,
    .use_channel, .channel_sel, .comparator_power_off, .capture_out, .comparator_irq, .irq
  );
  ccl_comp_model i_core
  (
    .use_bandgap, .use_channel, .channel_sel, .comparator_power_off, .pos_mv, .neg_mv, .ch_mv(64'h0),
    .comparator_raw
  );
  initial forever #5 ref_clk = ~ref_clk;
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  // Idle edge first so a released strobe is never raised in the same step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 50 && pready !== 1'b1; n++)
      @(posedge ref_clk);
    if (n == 50)
    begin
      errors++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0, "sfio");
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0, "csr");
    chk({26'h0, comparator_power_off, use_bandgap, use_channel, channel_sel}, 32'h0, "sel");
    foreach (rows[i])
    begin
      {converter_on, channel_select_field} <= rows[i][9:6];
      apb(1'b1, 12'h000, {24'h0, rows[i][25:18]});
      apb(1'b1, 12'h004, {24'h0, rows[i][17:10]});
      repeat (2) @(posedge ref_clk);
      chk({26'h0, comparator_power_off, use_bandgap, use_channel, channel_sel}, {26'h0, rows[i][5:0]}, "sel");
    end
    $display("select test done");
    for (int k = 0; k < 4; k++)
    begin
      m = k[1:0];
      fr = (m == 2'h0) | (m == 2'h3);
      ff = (m == 2'h0) | (m == 2'h2);
      apb(1'b1, 12'h004, {24'h0, 6'h04, m - 2'h1});
      apb(1'b1, 12'h004, {24'h0, 6'h04, m});
      apb(1'b1, 12'h004, {24'h0, 6'h07, m});
      pos_mv <= 8'h60;
      repeat (4) @(posedge ref_clk);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, {24'h0, 2'h0, 1'b1, fr, 2'h3, m}, "rise");
      chk({30'h0, capture_out, comparator_irq}, {30'h0, 1'b1, fr}, "rise out");
      apb(1'b1, 12'h004, {24'h0, 6'h07, m});
      pos_mv <= 8'h20;
      repeat (4) @(posedge ref_clk);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, {24'h0, 3'h0, ff, 2'h3, m}, "fall");
      chk({31'h0, capture_out}, 32'h0, "fall out");
    end
    apb(1'b1, 12'h004, 32'h03);
    apb(1'b1, 12'h004, 32'h00);
    apb(1'b1, 12'h004, 32'h08);
    pos_mv <= 8'h60;
    repeat (4) @(posedge ref_clk);
    apb(1'b1, 12'h004, 32'h08);
    apb(1'b0, 12'h008, 32'h0);
    chk({rd[30:0], irq}, 32'h2, "kept");
    apb(1'b1, 12'h00c, 32'h1);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({30'h0, irq, comparator_irq}, 32'h2, "global");
    apb(1'b1, 12'h008, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0, "w1c");
    global_irq_enable <= 1'b1;
    pos_mv <= 8'h20;
    repeat (5) @(posedge ref_clk);
    chk({30'h0, irq, comparator_irq}, 32'h3, "irq");
    vector_ack <= 1'b1;
    @(posedge ref_clk);
    vector_ack <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({30'h0, irq, comparator_irq}, 32'h0, "vector");
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped");
    $display("event test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
